// ---- cpm_consts.svh ----
// constants for the cpu programming model register block
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH
`define CPM_A_ACCD   4'h0
`define CPM_A_IDX1   4'h1
`define CPM_A_IDX2   4'h2
`define CPM_A_STACK  4'h3
`define CPM_A_PROG   4'h4
`define CPM_A_CCR    4'h5
`define CPM_A_OPER   4'h6
`define CPM_A_CMD    4'h7
`define CPM_A_STAT   4'h8
`define CPM_A_RES    4'h9
`define CPM_OP_LDA   5'h00
`define CPM_OP_STA   5'h01
`define CPM_OP_ADDA  5'h02
`define CPM_OP_CMPA  5'h03
`define CPM_OP_ABX   5'h04
`define CPM_OP_ABY   5'h05
`define CPM_OP_INX   5'h06
`define CPM_OP_DEX   5'h07
`define CPM_OP_INY   5'h08
`define CPM_OP_DEY   5'h09
`define CPM_OP_TAP   5'h0a
`define CPM_OP_TPA   5'h0b
`define CPM_OP_JSR   5'h0c
`define CPM_OP_RTS   5'h0d
`define CPM_OP_INT   5'h0e
`define CPM_OP_RTI   5'h0f
`define CPM_OP_STOP  5'h10
`define CPM_OP_EAX   5'h11
`define CPM_OP_EAY   5'h12
`define CPM_CMD_NMI  8
`define CPM_CCR_RST  8'hd0
`define CPM_CCR_XBIT 6
`define CPM_VEC_NORM 8'hff
`define CPM_VEC_TEST 8'hbf
`define CPM_VEC_POR  8'hfe
`define CPM_VEC_CMON 8'hfc
`define CPM_VEC_COP  8'hfa
`define CPM_CAUSE_POR  2'h0
`define CPM_CAUSE_CMON 2'h1
`define CPM_LAST_JSR 4'h1
`define CPM_LAST_INT 4'h8
`define CPM_LAST_RTS 4'h1
`define CPM_SYNC_WAIT 4'h2
`endif

// ---- cpm_pkg.sv ----
// types for the cpu programming model register block
package cpm_pkg;
  typedef struct packed {
    logic s;
    logic x;
    logic h;
    logic i;
    logic n;
    logic z;
    logic v;
    logic c;
  } cpm_ccr_t;
  typedef enum logic [10:0] {
    s_idle  = 11'h001,
    s_sync  = 11'h002,
    s_extra = 11'h004,
    s_push  = 11'h008,
    s_pull  = 11'h010,
    s_pwait = 11'h020,
    s_pcap  = 11'h040,
    s_va    = 11'h080,
    s_vb    = 11'h100,
    s_vc    = 11'h200,
    s_vd    = 11'h400
  } cpm_fsm_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cpm_mem_t;
  typedef struct packed {
    cpm_fsm_t    fsm;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [15:0] first_index_register;
    logic [15:0] second_index_register;
    logic [15:0] stack_pointer_reg;
    logic [15:0] program_counter_reg;
    cpm_ccr_t    condition_code_register;
    logic [15:0] operand;
    logic [4:0]  op;
    logic [3:0]  idx;
    logic [3:0]  last;
    logic        nmi;
    logic [15:0] vaddr;
    logic        pend;
    logic [15:0] pvec;
    logic        stopped;
    logic [15:0] ea;
    logic [7:0]  result;
    logic        wreq;
    logic [31:0] rdata;
    cpm_mem_t    mem;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
  } cpm_state_t;
endpackage

// ---- cpm_regs.sv ----
// cpu programming model registers with command engine and avalon slave
// How it works
// - two byte accumulators, also one double
// - add b to either index, unsigned
// - flag transfers use first accumulator only
// - indexed address is either index plus offset
// - second index ops take one extra cycle
// - stack grows down, push dec, pull inc
// - pointer marks next free stack byte
// - subroutine call pushes return, low first
// - subroutine return pulls address into counter
// - interrupt stacks counter, registers, then vectors
// - interrupt return pulls in reverse order
// - reset loads counter from six vectors
// - vector pairs by cause, ff or bf
// - flag register holds eight defined bits
// - load and store set n z v
// - call push, return pull and tpa leave flags alone
// - carry from carry or borrow
// - overflow set on signed overflow only
// - zero flag; compare subtracts without storing
// - index step touches only zero flag
// - negative copies result top bit
// - masked requests wait pending, unserviced
// - mask set after stacking, and by reset
// - half carry from bit three to four
// - request mask set by hardware only
// - stop is no-op while disable set
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_regs (
  input  wire logic        clk_in,              // 40 mhz clock
  input  wire logic        reset_in,            // async reset, high
  input  wire logic [3:0]  avs_address_in,      // word address
  input  wire logic        avs_read_in,         // read request
  input  wire logic        avs_write_in,        // write request
  input  wire logic [31:0] avs_writedata_in,    // write data
  output logic      [31:0] avs_readdata_out,    // read data
  output logic             avs_waitrequest_out, // wait
  output logic      [15:0] mem_addr_out,        // stack memory address
  output logic      [7:0]  mem_wdata_out,       // stack write byte
  output logic             mem_we_out,          // stack write strobe
  output logic             mem_re_out,          // stack read strobe
  input  wire logic [7:0]  mem_rdata_in,        // byte, cycle after read
  input  wire logic        boot_mode_in,        // test or boot strap
  input  wire logic [1:0]  reset_cause_in,      // reset cause code
  output logic             stopped_out          // low power stop
);
  cpm_pkg::cpm_state_t st;
  cpm_pkg::cpm_state_t st_next;
  logic       wr_go;
  logic       cmd_go;
  logic       can_write;
  logic [4:0] cmd_op;
  logic [7:0] o8;

  assign wr_go     = avs_write_in && !st.wreq;
  assign cmd_go    = wr_go && (avs_address_in == `CPM_A_CMD);
  assign cmd_op    = avs_writedata_in[4:0];
  assign o8        = st.operand[7:0];
  assign can_write = (st.fsm == cpm_pkg::s_idle) && !(st.pend && !st.condition_code_register.i);

  assign avs_readdata_out    = st.rdata;
  assign avs_waitrequest_out = st.wreq;
  assign mem_addr_out        = st.mem.addr;
  assign mem_wdata_out       = st.mem.wdata;
  assign mem_we_out          = st.mem.we;
  assign mem_re_out          = st.mem.re;
  assign stopped_out         = st.stopped;

  function automatic logic [31:0] rd_sel(input cpm_pkg::cpm_state_t s, input logic [3:0] a);
    case (a)
      `CPM_A_ACCD:  rd_sel = {16'h0000, s.acc_a, s.acc_b};
      `CPM_A_IDX1:  rd_sel = {16'h0000, s.first_index_register};
      `CPM_A_IDX2:  rd_sel = {16'h0000, s.second_index_register};
      `CPM_A_STACK: rd_sel = {16'h0000, s.stack_pointer_reg};
      `CPM_A_PROG:  rd_sel = {16'h0000, s.program_counter_reg};
      `CPM_A_CCR:   rd_sel = {24'h000000, s.condition_code_register};
      `CPM_A_OPER:  rd_sel = {16'h0000, s.operand};
      `CPM_A_CMD:   rd_sel = {27'h0000000, s.op};
      `CPM_A_STAT:  rd_sel = {29'h00000000, s.pend, s.stopped, s.fsm != cpm_pkg::s_idle};
      `CPM_A_RES:   rd_sel = {8'h00, s.result, s.ea};
      default:      rd_sel = 32'h00000000;
    endcase
  endfunction

  // stacking order: pcl pch yl yh xl xh a b ccr
  function automatic logic [7:0] push_byte(input cpm_pkg::cpm_state_t s, input logic [3:0] i);
    case (i)
      4'h0:    push_byte = s.program_counter_reg[7:0];
      4'h1:    push_byte = s.program_counter_reg[15:8];
      4'h2:    push_byte = s.second_index_register[7:0];
      4'h3:    push_byte = s.second_index_register[15:8];
      4'h4:    push_byte = s.first_index_register[7:0];
      4'h5:    push_byte = s.first_index_register[15:8];
      4'h6:    push_byte = s.acc_a;
      4'h7:    push_byte = s.acc_b;
      default: push_byte = s.condition_code_register;
    endcase
  endfunction

  always_comb begin
    logic [8:0]  sum9;
    logic [4:0]  half;
    logic [15:0] w16;
    sum9 = 9'h000;
    half = 5'h00;
    w16 = 16'h0000;
    st_next = st;
    st_next.sync1 = {boot_mode_in, reset_cause_in};
    st_next.sync2 = st.sync1;
    st_next.mem.we = 1'b0;
    st_next.mem.re = 1'b0;
    st_next.wreq = 1'b1;
    if ((avs_read_in || (avs_write_in && can_write)) && st.wreq) begin
      st_next.wreq = 1'b0;
      st_next.rdata = rd_sel(st, avs_address_in);
    end
    if (wr_go) begin
      case (avs_address_in)
        `CPM_A_ACCD: begin
          st_next.acc_a = avs_writedata_in[15:8];
          st_next.acc_b = avs_writedata_in[7:0];
        end
        `CPM_A_IDX1:  st_next.first_index_register = avs_writedata_in[15:0];
        `CPM_A_IDX2:  st_next.second_index_register = avs_writedata_in[15:0];
        `CPM_A_STACK: st_next.stack_pointer_reg = avs_writedata_in[15:0];
        `CPM_A_PROG:  st_next.program_counter_reg = avs_writedata_in[15:0];
        `CPM_A_CCR: begin
          st_next.condition_code_register = avs_writedata_in[7:0];
          st_next.condition_code_register.x = st.condition_code_register.x
                                              & avs_writedata_in[`CPM_CCR_XBIT];
        end
        `CPM_A_OPER:  st_next.operand = avs_writedata_in[15:0];
        default: begin
        end
      endcase
    end
    case (st.fsm)
      cpm_pkg::s_sync: begin
        st_next.idx = st.idx + 4'h1;
        if (st.idx == `CPM_SYNC_WAIT) begin
          st_next.vaddr[15:8] = st.sync2[2] ? `CPM_VEC_TEST : `CPM_VEC_NORM;
          st_next.vaddr[7:0] = (st.sync2[1:0] == `CPM_CAUSE_POR)  ? `CPM_VEC_POR :
                               (st.sync2[1:0] == `CPM_CAUSE_CMON) ? `CPM_VEC_CMON : `CPM_VEC_COP;
          st_next.fsm = cpm_pkg::s_va;
        end
      end
      cpm_pkg::s_idle: begin
        if (cmd_go) begin
          st_next.op = cmd_op;
          st_next.stopped = 1'b0;
          case (cmd_op)
            `CPM_OP_LDA, `CPM_OP_STA: begin
              w16[7:0] = (cmd_op == `CPM_OP_LDA) ? o8 : st.acc_a;
              st_next.acc_a = w16[7:0];
              st_next.result = w16[7:0];
              st_next.condition_code_register.n = w16[7];
              st_next.condition_code_register.z = (w16[7:0] == 8'h00);
              st_next.condition_code_register.v = 1'b0;
            end
            `CPM_OP_ADDA: begin
              sum9 = {1'b0, st.acc_a} + {1'b0, o8};
              half = {1'b0, st.acc_a[3:0]} + {1'b0, o8[3:0]};
              st_next.acc_a = sum9[7:0];
              st_next.result = sum9[7:0];
              st_next.condition_code_register.c = sum9[8];
              st_next.condition_code_register.h = half[4];
              st_next.condition_code_register.v = (st.acc_a[7] == o8[7]) && (sum9[7] != o8[7]);
              st_next.condition_code_register.z = (sum9[7:0] == 8'h00);
              st_next.condition_code_register.n = sum9[7];
            end
            `CPM_OP_CMPA: begin
              sum9 = {1'b0, st.acc_a} - {1'b0, o8};
              st_next.condition_code_register.c = sum9[8];
              st_next.condition_code_register.v = (st.acc_a[7] != o8[7]) && (sum9[7] != st.acc_a[7]);
              st_next.condition_code_register.z = (sum9[7:0] == 8'h00);
              st_next.condition_code_register.n = sum9[7];
            end
            `CPM_OP_ABX: st_next.first_index_register = st.first_index_register + {8'h00, st.acc_b};
            `CPM_OP_INX, `CPM_OP_DEX: begin
              w16 = (cmd_op == `CPM_OP_INX) ? st.first_index_register + 16'h0001
                                             : st.first_index_register - 16'h0001;
              st_next.first_index_register = w16;
              st_next.condition_code_register.z = (w16 == 16'h0000);
            end
            `CPM_OP_ABY, `CPM_OP_INY, `CPM_OP_DEY, `CPM_OP_EAY: st_next.fsm = cpm_pkg::s_extra;
            `CPM_OP_TAP: begin
              st_next.condition_code_register = st.acc_a;
              st_next.condition_code_register.x = st.condition_code_register.x & st.acc_a[`CPM_CCR_XBIT];
            end
            `CPM_OP_TPA: st_next.acc_a = st.condition_code_register;
            `CPM_OP_JSR: begin
              st_next.idx = 4'h0;
              st_next.last = `CPM_LAST_JSR;
              st_next.fsm = cpm_pkg::s_push;
            end
            `CPM_OP_RTS, `CPM_OP_RTI: begin
              st_next.idx = (cmd_op == `CPM_OP_RTS) ? `CPM_LAST_RTS : `CPM_LAST_INT;
              st_next.fsm = cpm_pkg::s_pull;
            end
            `CPM_OP_INT: begin
              if (avs_writedata_in[`CPM_CMD_NMI] || !st.condition_code_register.i) begin
                st_next.nmi = avs_writedata_in[`CPM_CMD_NMI];
                st_next.vaddr = st.operand;
                st_next.idx = 4'h0;
                st_next.last = `CPM_LAST_INT;
                st_next.fsm = cpm_pkg::s_push;
              end else begin
                st_next.pend = 1'b1;
                st_next.pvec = st.operand;
              end
            end
            `CPM_OP_STOP: st_next.stopped = !st.condition_code_register.s;
            `CPM_OP_EAX: st_next.ea = st.first_index_register + {8'h00, o8};
            default: begin
            end
          endcase
        end else if (st.pend && !st.condition_code_register.i) begin
          st_next.pend = 1'b0;
          st_next.op = `CPM_OP_INT;
          st_next.nmi = 1'b0;
          st_next.stopped = 1'b0;
          st_next.vaddr = st.pvec;
          st_next.idx = 4'h0;
          st_next.last = `CPM_LAST_INT;
          st_next.fsm = cpm_pkg::s_push;
        end
      end
      cpm_pkg::s_extra: begin
        st_next.fsm = cpm_pkg::s_idle;
        case (st.op)
          `CPM_OP_ABY: st_next.second_index_register = st.second_index_register + {8'h00, st.acc_b};
          `CPM_OP_EAY: st_next.ea = st.second_index_register + {8'h00, o8};
          default: begin
            w16 = (st.op == `CPM_OP_INY) ? st.second_index_register + 16'h0001
                                          : st.second_index_register - 16'h0001;
            st_next.second_index_register = w16;
            st_next.condition_code_register.z = (w16 == 16'h0000);
          end
        endcase
      end
      cpm_pkg::s_push: begin
        st_next.mem.addr = st.stack_pointer_reg;
        st_next.mem.wdata = push_byte(st, st.idx);
        st_next.mem.we = 1'b1;
        st_next.stack_pointer_reg = st.stack_pointer_reg - 16'h0001;
        st_next.idx = st.idx + 4'h1;
        if (st.idx == st.last) begin
          if (st.op == `CPM_OP_JSR) begin
            st_next.program_counter_reg = st.operand;
            st_next.fsm = cpm_pkg::s_idle;
          end else begin
            st_next.condition_code_register.i = 1'b1;
            st_next.condition_code_register.x = st.condition_code_register.x | st.nmi;
            st_next.fsm = cpm_pkg::s_va;
          end
        end
      end
      cpm_pkg::s_pull: begin
        st_next.stack_pointer_reg = st.stack_pointer_reg + 16'h0001;
        st_next.mem.addr = st.stack_pointer_reg + 16'h0001;
        st_next.mem.re = 1'b1;
        st_next.fsm = cpm_pkg::s_pwait;
      end
      cpm_pkg::s_pwait: st_next.fsm = cpm_pkg::s_pcap;
      cpm_pkg::s_pcap: begin
        case (st.idx)
          4'h0: st_next.program_counter_reg[7:0] = mem_rdata_in;
          4'h1: st_next.program_counter_reg[15:8] = mem_rdata_in;
          4'h2: st_next.second_index_register[7:0] = mem_rdata_in;
          4'h3: st_next.second_index_register[15:8] = mem_rdata_in;
          4'h4: st_next.first_index_register[7:0] = mem_rdata_in;
          4'h5: st_next.first_index_register[15:8] = mem_rdata_in;
          4'h6: st_next.acc_a = mem_rdata_in;
          4'h7: st_next.acc_b = mem_rdata_in;
          default: begin
            st_next.condition_code_register = mem_rdata_in;
            st_next.condition_code_register.x = st.condition_code_register.x
                                                & mem_rdata_in[`CPM_CCR_XBIT];
          end
        endcase
        st_next.idx = st.idx - 4'h1;
        st_next.fsm = (st.idx == 4'h0) ? cpm_pkg::s_idle : cpm_pkg::s_pull;
      end
      cpm_pkg::s_va: begin
        st_next.mem.addr = st.vaddr;
        st_next.mem.re = 1'b1;
        st_next.fsm = cpm_pkg::s_vb;
      end
      cpm_pkg::s_vb: begin
        st_next.mem.addr = st.vaddr + 16'h0001;
        st_next.mem.re = 1'b1;
        st_next.fsm = cpm_pkg::s_vc;
      end
      cpm_pkg::s_vc: begin
        st_next.program_counter_reg[15:8] = mem_rdata_in;
        st_next.fsm = cpm_pkg::s_vd;
      end
      cpm_pkg::s_vd: begin
        st_next.program_counter_reg[7:0] = mem_rdata_in;
        st_next.fsm = cpm_pkg::s_idle;
      end
      default: st_next.fsm = cpm_pkg::s_idle;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
      st.fsm <= cpm_pkg::s_sync;
      st.condition_code_register <= `CPM_CCR_RST;
      st.wreq <= 1'b1;
    end else begin
      st <= st_next;
    end
  end

  a_stack_order: assert property (@(posedge clk_in) disable iff (reset_in)
    mem_we_out |-> mem_addr_out == st.stack_pointer_reg + 16'h0001)
    else $error("push address is not the pre-decrement pointer");
  a_addb_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    cmd_go && cmd_op == `CPM_OP_ABX |=> st.condition_code_register == $past(st.condition_code_register)
      && st.first_index_register == $past(st.first_index_register) + {8'h00, $past(st.acc_b)})
    else $error("add b to index changed flags or sum wrong");
  a_inx_zonly: assert property (@(posedge clk_in) disable iff (reset_in)
    cmd_go && cmd_op == `CPM_OP_INX |=> st.condition_code_register.z == (st.first_index_register == 16'h0000)
      && {st.condition_code_register.n, st.condition_code_register.v, st.condition_code_register.c}
         == $past({st.condition_code_register.n, st.condition_code_register.v, st.condition_code_register.c}))
    else $error("index increment flags wrong");
  a_load_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    cmd_go && cmd_op == `CPM_OP_LDA |=> st.condition_code_register.n == st.acc_a[7]
      && st.condition_code_register.z == (st.acc_a == 8'h00) && !st.condition_code_register.v)
    else $error("load flags wrong");
  a_mask_pend: assert property (@(posedge clk_in) disable iff (reset_in)
    st.pend && st.condition_code_register.i |=> st.pend)
    else $error("masked request serviced");
  a_xmask_hw: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(st.condition_code_register.x) |-> $past(st.fsm == cpm_pkg::s_push) && $past(st.nmi))
    else $error("request mask set outside acknowledge");
  a_call_low: assert property (@(posedge clk_in) disable iff (reset_in)
    cmd_go && cmd_op == `CPM_OP_JSR |-> ##2 mem_we_out && mem_wdata_out == $past(st.program_counter_reg[7:0], 2))
    else $error("call did not push low byte first");
  a_stop_nop: assert property (@(posedge clk_in) disable iff (reset_in)
    cmd_go && cmd_op == `CPM_OP_STOP && st.condition_code_register.s |=> !stopped_out)
    else $error("stop entered while disabled");
endmodule

// ---- tb_cpu_programming_model_regs.sv ----
// self-checking testbench for the cpu programming model register block
`timescale 1ns/1ps
`include "cpm_consts.svh"
module tb_cpu_programming_model_regs;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [15:0] mem_addr_out;
  logic [7:0]  mem_wdata_out;
  logic        mem_we_out;
  logic        mem_re_out;
  logic [7:0]  mem_rdata_in = 8'h00;
  logic        boot_mode_in = 1'b0;
  logic [1:0]  reset_cause_in = 2'h0;
  logic        stopped_out;
  logic [7:0]  mem [0:65535];
  int          err_count = 0;
  int          n_checks = 0;
  integer      seed = 32'hb2b1;
  logic [7:0]  a, b, o, f;
  logic [15:0] x, v;
  logic [8:0]  s;
  logic [7:0]  ca [3] = '{8'h7f, 8'h00, 8'hff};
  logic [7:0]  co [3] = '{8'h01, 8'h00, 8'h01};
  logic [4:0]  io [4] = '{`CPM_OP_INX, `CPM_OP_DEX, `CPM_OP_INY, `CPM_OP_DEY};
  logic [15:0] iv [4] = '{16'hffff, 16'h0001, 16'hfffe, 16'h0000};
  logic [7:0]  stk [9] = '{8'h34, 8'h12, 8'h44, 8'h33, 8'h22, 8'h11, 8'h55, 8'h66, 8'h00};

  always #12.5 clk_in = ~clk_in;

  cpm_regs cpm_regs_inst (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
    .mem_re_out(mem_re_out), .mem_rdata_in(mem_rdata_in), .boot_mode_in(boot_mode_in),
    .reset_cause_in(reset_cause_in), .stopped_out(stopped_out));

  // stack ram, read byte valid only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (mem_we_out === 1'b1) mem[mem_addr_out] <= mem_wdata_out;
    mem_rdata_in <= (mem_re_out === 1'b1) ? mem[mem_addr_out] : ~mem_rdata_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string t, input logic [31:0] m = '1);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, t, got & m, exp & m);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address_in <= ad;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 400);
    r = avs_readdata_out;
    if (n >= 400) chk(32'h0, 32'h1, "bus timeout");
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ad, d, r);
  endtask

  task automatic rd(input logic [3:0] ad, input logic [31:0] e, input string t, input logic [31:0] m = '1);
    logic [31:0] r;
    bus(1'b0, ad, 32'h0, r);
    chk(r, e, t, m);
  endtask

  task automatic idle();
    logic [31:0] r;
    r = 32'h1;
    for (int k = 0; k < 60 && r[0] !== 1'b0; k++) bus(1'b0, `CPM_A_STAT, 32'h0, r);
    chk({31'h0, r[0]}, 32'h0, "engine idle");
  endtask

  task automatic cmd(input logic [4:0] op, input logic [15:0] d);
    wr(`CPM_A_OPER, {16'h0, d});
    wr(`CPM_A_CMD, {27'h0, op});
    idle();
  endtask

  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(25.0 * 40000);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    for (int k = 0; k < 65536; k++) mem[k] = k[7:0] ^ 8'h5a;
    for (int m = 0; m < 6; m++) begin
      @(posedge clk_in);
      reset_in <= 1'b1;
      boot_mode_in <= m[0];
      reset_cause_in <= m[2:1];
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      idle();
      v[15:8] = m[0] ? `CPM_VEC_TEST : `CPM_VEC_NORM;
      v[7:0] = (m[2:1] == 0) ? `CPM_VEC_POR : ((m[2:1] == 1) ? `CPM_VEC_CMON : `CPM_VEC_COP);
      rd(`CPM_A_PROG, {mem[v], mem[v + 16'h1]}, "reset vector");
      rd(`CPM_A_CCR, 32'hd0, "reset flags");
    end
    f = 8'hd0;
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      b = $random(seed);
      o = $random(seed);
      if (i < 3) {a, o} = {ca[i], co[i]};
      wr(`CPM_A_ACCD, {24'h0, b});
      cmd(`CPM_OP_LDA, {8'h0, a});
      f[3:1] = {a[7], a == 8'h00, 1'b0};
      rd(`CPM_A_ACCD, {a, b}, "load");
      rd(`CPM_A_CCR, f, "load flags");
      s = {1'b0, a} + {1'b0, o};
      cmd(`CPM_OP_ADDA, {8'h0, o});
      f[5] = ({1'b0, a[3:0]} + {1'b0, o[3:0]}) > 5'h0f;
      f[3:0] = {s[7], s[7:0] == 8'h00, (a[7] == o[7]) && (s[7] != a[7]), s[8]};
      rd(`CPM_A_ACCD, {s[7:0], b}, "add");
      rd(`CPM_A_CCR, f, "add flags");
      a = s[7:0];
      o = $random(seed);
      s = {1'b0, a} - {1'b0, o};
      cmd(`CPM_OP_CMPA, {8'h0, o});
      f[3:0] = {s[7], s[7:0] == 8'h00, (a[7] != o[7]) && (s[7] != a[7]), s[8]};
      rd(`CPM_A_ACCD, {a, b}, "compare keeps a");
      rd(`CPM_A_CCR, f, "compare flags");
      x = $random(seed);
      wr(`CPM_A_IDX1, x);
      wr(`CPM_A_IDX2, ~x);
      cmd(`CPM_OP_ABX, 16'h0);
      cmd(`CPM_OP_ABY, 16'h0);
      v = x + b;
      rd(`CPM_A_IDX1, {16'h0, v}, "add b to index1");
      v = ~x + b;
      rd(`CPM_A_IDX2, {16'h0, v}, "add b to index2");
      rd(`CPM_A_CCR, f, "index add flags");
    end
    for (int k = 0; k < 4; k++) begin
      wr(k < 2 ? `CPM_A_IDX1 : `CPM_A_IDX2, iv[k]);
      cmd(io[k], 16'h0);
      x = k[0] ? iv[k] - 16'h1 : iv[k] + 16'h1;
      f[2] = (x == 16'h0);
      rd(k < 2 ? `CPM_A_IDX1 : `CPM_A_IDX2, x, "index step");
      rd(`CPM_A_CCR, f, "index step flags");
    end
    wr(`CPM_A_IDX1, 16'hff20);
    wr(`CPM_A_IDX2, 16'h1000);
    cmd(`CPM_OP_EAX, 16'h00f0);
    rd(`CPM_A_RES, 32'h0010, "indexed addr 1", 32'hffff);
    cmd(`CPM_OP_EAY, 16'h00f0);
    rd(`CPM_A_RES, 32'h10f0, "indexed addr 2", 32'hffff);
    wr(`CPM_A_ACCD, 32'h8000);
    cmd(`CPM_OP_STA, 16'h0);
    f[3:1] = 3'b100;
    rd(`CPM_A_RES, 32'h00800000, "store", 32'h00ff0000);
    rd(`CPM_A_CCR, f, "store flags");
    wr(`CPM_A_ACCD, 32'h0);
    cmd(`CPM_OP_TAP, 16'h0);
    rd(`CPM_A_CCR, 32'h00, "a to flags");
    wr(`CPM_A_ACCD, 32'hff00);
    cmd(`CPM_OP_TAP, 16'h0);
    rd(`CPM_A_CCR, 32'hbf, "x not settable");
    wr(`CPM_A_ACCD, 32'h0);
    cmd(`CPM_OP_TPA, 16'h0);
    rd(`CPM_A_ACCD, 32'hbf00, "flags to a");
    cmd(`CPM_OP_STOP, 16'h0);
    chk({31'h0, stopped_out}, 32'h0, "stop disabled");
    wr(`CPM_A_CCR, 32'h0);
    cmd(`CPM_OP_STOP, 16'h0);
    chk({31'h0, stopped_out}, 32'h1, "stop entered");
    wr(`CPM_A_STACK, 32'h0400);
    wr(`CPM_A_PROG, 32'h1234);
    cmd(`CPM_OP_JSR, 16'h8000);
    chk({mem[16'h0400], mem[16'h03ff]}, 32'h3412, "return bytes");
    rd(`CPM_A_STACK, 32'h03fe, "stack after call");
    rd(`CPM_A_PROG, 32'h8000, "call target");
    cmd(`CPM_OP_RTS, 16'h0);
    rd(`CPM_A_PROG, 32'h1234, "return pc");
    rd(`CPM_A_STACK, 32'h0400, "stack after return");
    wr(`CPM_A_CCR, 32'h10);
    wr(`CPM_A_IDX1, 32'h1122);
    wr(`CPM_A_IDX2, 32'h3344);
    wr(`CPM_A_ACCD, 32'h5566);
    cmd(`CPM_OP_INT, 16'h2000);
    rd(`CPM_A_STAT, 32'h4, "pending", 32'h4);
    rd(`CPM_A_PROG, 32'h1234, "masked not taken");
    wr(`CPM_A_CCR, 32'h0);
    idle();
    for (int k = 0; k < 9; k++) chk(mem[16'h0400 - k], stk[k], "stacked byte");
    rd(`CPM_A_STACK, 32'h03f7, "stack after entry");
    rd(`CPM_A_CCR, 32'h10, "mask on entry");
    rd(`CPM_A_PROG, {mem[16'h2000], mem[16'h2001]}, "service vector");
    wr(`CPM_A_IDX1, 32'h0);
    wr(`CPM_A_ACCD, 32'h0);
    cmd(`CPM_OP_RTI, 16'h0);
    rd(`CPM_A_IDX1, 32'h1122, "restored index");
    rd(`CPM_A_ACCD, 32'h5566, "restored acc");
    rd(`CPM_A_PROG, 32'h1234, "resume pc");
    rd(`CPM_A_STACK, 32'h0400, "stack after resume");
    rd(`CPM_A_CCR, 32'h00, "restored flags");
    wr(`CPM_A_OPER, 32'h2000);
    wr(`CPM_A_CMD, 32'h10e);
    idle();
    rd(`CPM_A_CCR, 32'h50, "nonmaskable sets both masks");
    rd(`CPM_A_STACK, 32'h03f7, "stack after nonmaskable");
    wr(4'hc, 32'hffffffff);
    rd(4'hb, 32'h0, "unmapped read");
    report_and_stop();
  end
endmodule
